// [verilog/cstat_pkg.sv]
/*
 Constants and carrier types for the copper status and event-enable
 registers. Assumes one 100 MHz system clock and a 5-bit register address.
*/
`default_nettype none
package cstat_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam logic [4:0] OFS_LINK_STATUS = 5'h11;
   localparam logic [4:0] OFS_EVENT_ENABLE = 5'h12;

   // Status field positions
   localparam int ST_SPEED_HI = 15;
   localparam int ST_SPEED_LO = 14;
   localparam int ST_DUPLEX = 13;
   localparam int ST_PAGE_RX = 12;
   localparam int ST_RESOLVED = 11;
   localparam int ST_LINK_RT = 10;
   localparam int ST_TX_PAUSE = 9;
   localparam int ST_RX_PAUSE = 8;
   localparam int ST_MDIX = 6;
   localparam int ST_ENERGY = 4;
   localparam int ST_GLINK = 3;
   localparam int ST_POLARITY = 1;
   localparam int ST_JABBER = 0;

   // Event and enable bit positions
   localparam int EV_AN_ERROR = 15;
   localparam int EV_SPEED = 14;
   localparam int EV_DUPLEX = 13;
   localparam int EV_PAGE = 12;
   localparam int EV_AN_DONE = 11;
   localparam int EV_LINK = 10;
   localparam int EV_SYMBOL = 9;
   localparam int EV_FALSE_CARRIER = 8;
   localparam int EV_XOVER = 6;
   localparam int EV_ENERGY = 4;
   localparam int EV_AN_NO_LINK = 3;
   localparam int EV_POLARITY = 1;
   localparam int EV_JABBER = 0;
   // Implemented enables; 7, 5 and 2 stay zero
   localparam logic [15:0] ENABLE_MASK = 16'hFF5B;

   localparam logic [1:0] SPEED_10 = 2'h0;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;
   localparam logic [1:0] SPEED_RST = 2'h2;
   localparam logic MDIX_RST = 1'b1;

   typedef enum logic [1:0] {
      XOVER_MDI = 2'h0,
      XOVER_MDIX = 2'h1,
      XOVER_RSVD = 2'h2,
      XOVER_AUTO = 2'h3
   } cstat_xover_t;

   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } cstat_bus_t;

   typedef struct packed {
      logic [1:0] speed;
      logic duplex;
      logic tx_pause;
      logic rx_pause;
      logic an_enable;
      logic an_done;
      logic an_restart;
      logic page_rx;
      logic link_rt;
      logic mdix_auto;
      logic energy_sleep;
      logic link_global;
      logic polarity_rt;
      logic [3:0] pair_polarity;
      logic jabber_rt;
      logic symbol_err;
      logic false_carrier;
      logic an_no_link;
      logic ms_fault;
      logic pd_fault;
      logic no_hcd;
      logic link_fail_after_an;
   } cstat_link_in_t;

   typedef struct packed {
      cstat_xover_t xover_mode;
      logic pol_rev_disable;
   } cstat_cfg_t;
endpackage
`default_nettype wire

// [verilog/cstat_xover.sv]
/*
 Crossover mode holder and crossover status bit.
 Assumes sw_reset is a one-cycle pulse on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module cstat_xover (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sw_reset,
   input wire cstat_pkg::cstat_xover_t mode_cfg,
   input wire logic mdix_auto,
   output logic mdix
);
   typedef struct packed {
      cstat_pkg::cstat_xover_t mode;
      logic mdix;
   } cstat_xover_state_t;

   cstat_xover_state_t state_reg;
   cstat_xover_state_t state_next;

   always_comb
   begin
      state_next = state_reg;
      // Disruptive change, so only taken at soft reset
      if (sw_reset)
      begin
         // Reserved code falls back to automatic
         if (mode_cfg == cstat_pkg::XOVER_RSVD)
            state_next.mode = cstat_pkg::XOVER_AUTO;
         else
            state_next.mode = mode_cfg;
      end
      case (state_next.mode)
         cstat_pkg::XOVER_MDI: state_next.mdix = 1'b0;
         cstat_pkg::XOVER_MDIX: state_next.mdix = 1'b1;
         cstat_pkg::XOVER_AUTO: state_next.mdix = mdix_auto;
         default: state_next.mdix = mdix_auto;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_reg.mode <= cstat_pkg::XOVER_AUTO;
         state_reg.mdix <= cstat_pkg::MDIX_RST;
      end
      else
         state_reg <= state_next;
   end

   assign mdix = state_reg.mdix;
endmodule
`default_nettype wire

// [verilog/cstat_irq_en.sv]
/*
 Event enable register and interrupt output.
 Assumes ev_latched comes from the event register on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module cstat_irq_en (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [15:0] wdata,
   input wire logic [15:0] ev_latched,
   output logic [15:0] enable,
   output logic irq
);
   typedef struct packed {
      logic [15:0] enable;
      logic irq;
   } cstat_irq_state_t;

   cstat_irq_state_t state_reg;
   cstat_irq_state_t state_next;

   always_comb
   begin
      state_next = state_reg;
      // Soft reset deliberately not an input: enables are kept
      if (wr_en)
         state_next.enable = wdata & cstat_pkg::ENABLE_MASK;
      state_next.irq = |(ev_latched & state_reg.enable);
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_reg.enable <= 16'h0000;
         state_reg.irq <= 1'b0;
      end
      else
         state_reg <= state_next;
   end

   assign enable = state_reg.enable;
   assign irq = state_reg.irq;
endmodule
`default_nettype wire

// [verilog/cstat_regs.sv]
/*
 Copper link status register and event enable register, with event
 pulses for the event register and the interrupt output.
 Assumes link inputs, config and sw_reset come from logic on clk_sys,
 and ev_latched from the event register held elsewhere.
*/
// Chosen here: the address-and-strobe port.
// What this block does
// - Speed at bits 15:14: 00/01/10 for 10/100/1000, reset 10.
// - Duplex at bit 13, 1 full, 0 half, valid once resolved.
// - Resolved flag bit 11 set on negotiation done, held 1 if disabled.
// - Page-received bit 12 latches high until read, resets 0.
// - Bit 10 shows real-time copper link, 1 up.
// - Bits 9 and 8 show transmit and receive pause, informational only.
// - Bit 6 crossover state, 1 MDIX, reset 1, follows manual setting.
// - New crossover mode takes effect only at soft reset.
// - Bit 4 reads 1 while port sleeps for lack of energy.
// - Bit 3 shows global copper link status.
// - Bit 1 real-time polarity, forced normal when reversal disabled.
// - At 1000 Mbps per-pair polarity is given on its own field.
// - Bit 0 shows real-time jabber.
// - Enable bits read/write, 1 enables, reset 0, kept over soft reset.
// - Enable bit positions per event source, 15 down to 0.
// - Negotiation error is any of four fault conditions.
// - Crossover control 00 MDI, 01 MDIX, 11 auto, 10 reserved.
`timescale 1ns/10ps
`default_nettype none
module cstat_regs (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sw_reset,
   input wire cstat_pkg::cstat_bus_t bus,
   output logic [15:0] rdata,
   input wire cstat_pkg::cstat_link_in_t link,
   input wire cstat_pkg::cstat_cfg_t cfg,
   input wire logic [15:0] ev_latched,
   output logic [15:0] event_pulse,
   output logic [3:0] pair_polarity,
   output logic irq
);
   localparam int NCHG = 6;

   typedef struct packed {
      logic [1:0] speed;
      logic duplex;
      logic page_rx;
      logic resolved;
      logic link_rt;
      logic tx_pause;
      logic rx_pause;
      logic energy;
      logic glink;
      logic polarity;
      logic jabber;
      logic [3:0] pair_pol;
      logic [15:0] rdata;
      logic [15:0] events;
   } cstat_state_t;

   cstat_state_t state_reg;
   cstat_state_t state_next;
   logic mdix;
   logic mdix_d_reg;
   logic [15:0] enable;
   logic rd_status;
   logic rd_enable;
   logic wr_enable;
   logic an_error;
   logic [15:0] status_word;
   logic [NCHG-1:0] chg;
   logic [15:0] chg_events;

   function automatic logic hit(
      input logic [4:0] addr,
      input logic [4:0] ofs
   );
      hit = (addr == ofs);
   endfunction

   assign rd_status = bus.rd && hit(bus.addr, cstat_pkg::OFS_LINK_STATUS);
   assign rd_enable = bus.rd && hit(bus.addr, cstat_pkg::OFS_EVENT_ENABLE);
   // Writes to the status offset decode to nothing
   assign wr_enable = bus.wr && hit(bus.addr, cstat_pkg::OFS_EVENT_ENABLE);

   assign an_error = link.ms_fault | link.pd_fault | link.no_hcd
      | link.link_fail_after_an;

   cstat_xover u_xover (
      .clk_sys(clk_sys),
      .rst(rst),
      .sw_reset(sw_reset),
      .mode_cfg(cfg.xover_mode),
      .mdix_auto(link.mdix_auto),
      .mdix(mdix)
   );

   cstat_irq_en u_irq_en (
      .clk_sys(clk_sys),
      .rst(rst),
      .wr_en(wr_enable),
      .wdata(bus.wdata),
      .ev_latched(ev_latched),
      .enable(enable),
      .irq(irq)
   );

   // Status image; reserved bits 7, 5, 2 left at zero
   always_comb
   begin
      status_word = 16'h0000;
      status_word[cstat_pkg::ST_SPEED_HI:cstat_pkg::ST_SPEED_LO] =
         state_reg.speed;
      status_word[cstat_pkg::ST_DUPLEX] = state_reg.duplex;
      status_word[cstat_pkg::ST_PAGE_RX] = state_reg.page_rx;
      status_word[cstat_pkg::ST_RESOLVED] = state_reg.resolved;
      status_word[cstat_pkg::ST_LINK_RT] = state_reg.link_rt;
      status_word[cstat_pkg::ST_TX_PAUSE] = state_reg.tx_pause;
      status_word[cstat_pkg::ST_RX_PAUSE] = state_reg.rx_pause;
      status_word[cstat_pkg::ST_MDIX] = mdix;
      status_word[cstat_pkg::ST_ENERGY] = state_reg.energy;
      status_word[cstat_pkg::ST_GLINK] = state_reg.glink;
      status_word[cstat_pkg::ST_POLARITY] = state_reg.polarity;
      status_word[cstat_pkg::ST_JABBER] = state_reg.jabber;
   end

   // Change detectors feeding the event register
   logic [NCHG-1:0] chg_old;
   logic [NCHG-1:0] chg_new;
   localparam int CHG_POS [NCHG] = '{
      cstat_pkg::EV_DUPLEX, cstat_pkg::EV_LINK, cstat_pkg::EV_ENERGY,
      cstat_pkg::EV_POLARITY, cstat_pkg::EV_XOVER, cstat_pkg::EV_SPEED
   };

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         mdix_d_reg <= cstat_pkg::MDIX_RST;
      else
         mdix_d_reg <= mdix;
   end

   assign chg_old = {mdix_d_reg, state_reg.polarity, state_reg.energy,
      state_reg.link_rt, state_reg.duplex, 1'b0};
   assign chg_new = {mdix, state_next.polarity, state_next.energy,
      state_next.link_rt, state_next.duplex,
      (state_next.speed != state_reg.speed)};

   genvar gi;
   generate
      for (gi = 0; gi < NCHG; gi++)
      begin : g_chg
         assign chg[gi] = chg_old[gi] ^ chg_new[gi];
      end
   endgenerate

   always_comb
   begin
      chg_events = 16'h0000;
      chg_events[cstat_pkg::EV_SPEED] = chg[0];
      chg_events[cstat_pkg::EV_DUPLEX] = chg[1];
      chg_events[cstat_pkg::EV_LINK] = chg[2];
      chg_events[cstat_pkg::EV_ENERGY] = chg[3];
      chg_events[cstat_pkg::EV_POLARITY] = chg[4];
      chg_events[cstat_pkg::EV_XOVER] = chg[5];
   end

   always_comb
   begin
      state_next = state_reg;

      // Real-time mirrors
      state_next.link_rt = link.link_rt;
      state_next.energy = link.energy_sleep;
      state_next.glink = link.link_global;
      state_next.jabber = link.jabber_rt;
      if (cfg.pol_rev_disable)
         state_next.polarity = 1'b0;
      else
         state_next.polarity = link.polarity_rt;

      // Restart drops resolution; completion or disabled sets it
      if (link.an_restart)
         state_next.resolved = 1'b0;
      if (link.an_done || !link.an_enable)
         state_next.resolved = 1'b1;

      // Resolved results captured only while resolution holds
      if (state_next.resolved)
      begin
         state_next.speed = link.speed;
         state_next.duplex = link.duplex;
         // Reflected only, nothing inside reads them
         state_next.tx_pause = link.tx_pause;
         state_next.rx_pause = link.rx_pause;
      end

      // Per-pair field only meaningful at gigabit
      if (state_next.speed == cstat_pkg::SPEED_1000)
         state_next.pair_pol = link.pair_polarity;
      else
         state_next.pair_pol = 4'h0;

      // Set beats the clear-on-read
      if (rd_status)
         state_next.page_rx = 1'b0;
      if (link.page_rx)
         state_next.page_rx = 1'b1;

      // Soft reset clears what is not retained
      if (sw_reset)
      begin
         state_next.page_rx = 1'b0;
         state_next.resolved = 1'b0;
         state_next.link_rt = 1'b0;
         state_next.tx_pause = 1'b0;
         state_next.rx_pause = 1'b0;
         state_next.energy = 1'b0;
         state_next.glink = 1'b0;
         state_next.polarity = 1'b0;
         state_next.jabber = 1'b0;
      end

      state_next.events = chg_events;
      state_next.events[cstat_pkg::EV_AN_ERROR] = an_error;
      state_next.events[cstat_pkg::EV_PAGE] = link.page_rx;
      state_next.events[cstat_pkg::EV_AN_DONE] = link.an_done;
      state_next.events[cstat_pkg::EV_SYMBOL] = link.symbol_err;
      state_next.events[cstat_pkg::EV_FALSE_CARRIER] = link.false_carrier;
      state_next.events[cstat_pkg::EV_AN_NO_LINK] = link.an_no_link;
      state_next.events[cstat_pkg::EV_JABBER] =
         link.jabber_rt & ~state_reg.jabber;

      // Read data for the cycle after the strobe only
      if (rd_status)
         state_next.rdata = status_word;
      else if (rd_enable)
         state_next.rdata = enable;
      else
         state_next.rdata = 16'h0000;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_reg.speed <= cstat_pkg::SPEED_RST;
         state_reg.duplex <= 1'b0;
         state_reg.page_rx <= 1'b0;
         state_reg.resolved <= 1'b0;
         state_reg.link_rt <= 1'b0;
         state_reg.tx_pause <= 1'b0;
         state_reg.rx_pause <= 1'b0;
         state_reg.energy <= 1'b0;
         state_reg.glink <= 1'b0;
         state_reg.polarity <= 1'b0;
         state_reg.jabber <= 1'b0;
         state_reg.pair_pol <= 4'h0;
         state_reg.rdata <= 16'h0000;
         state_reg.events <= 16'h0000;
      end
      else
         state_reg <= state_next;
   end

   assign rdata = state_reg.rdata;
   assign event_pulse = state_reg.events;
   assign pair_polarity = state_reg.pair_pol;
endmodule
`default_nettype wire

// [bench/cstat_regs_props.sv]
/*
 Port checker for the copper status and event-enable registers.
 Assumes one clock domain; bound to every cstat_regs instance.
*/
`timescale 1ns/10ps
`default_nettype none
module cstat_regs_props (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sw_reset,
   input wire cstat_pkg::cstat_bus_t bus,
   input wire logic [15:0] rdata,
   input wire cstat_pkg::cstat_link_in_t link,
   input wire cstat_pkg::cstat_cfg_t cfg,
   input wire logic [15:0] ev_latched,
   input wire logic [15:0] event_pulse,
   input wire logic [3:0] pair_polarity,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   sequence an_fault_s;
      link.ms_fault || link.pd_fault || link.no_hcd
         || link.link_fail_after_an;
   endsequence
   sequence odd_read_s;
      bus.rd && bus.addr != 5'h11 && bus.addr != 5'h12;
   endsequence
   idle_read_a: assert property (
      !bus.rd |=> rdata == 16'h0000)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (
      odd_read_s |=> rdata == 16'h0000)
      else $error("unmapped read returned data");
   page_event_a: assert property (
      link.page_rx |=> event_pulse[12])
      else $error("page arrival gave no event");
   an_error_a: assert property (
      an_fault_s |=> event_pulse[15])
      else $error("negotiation fault gave no event");
   symbol_event_a: assert property (
      link.symbol_err |=> event_pulse[9])
      else $error("symbol error gave no event");
   jabber_event_a: assert property (
      $rose(link.jabber_rt) |=> event_pulse[0])
      else $error("jabber onset gave no event");
   energy_event_a: assert property (
      $changed(link.energy_sleep) |-> ##[1:2] event_pulse[4])
      else $error("energy change gave no event");
   reserved_quiet_a: assert property (
      (event_pulse & ~cstat_pkg::ENABLE_MASK) == 16'h0000)
      else $error("event on a reserved position");
   irq_idle_a: assert property (
      $past(ev_latched) == 16'h0000 |-> !irq)
      else $error("interrupt without latched event");
   pair_source_a: assert property (
      (pair_polarity & ~$past(link.pair_polarity)) == 4'h0)
      else $error("pair polarity bit without cause");
endmodule
bind cstat_regs cstat_regs_props u_props (
   .clk_sys(clk_sys),
   .rst(rst),
   .sw_reset(sw_reset),
   .bus(bus),
   .rdata(rdata),
   .link(link),
   .cfg(cfg),
   .ev_latched(ev_latched),
   .event_pulse(event_pulse),
   .pair_polarity(pair_polarity),
   .irq(irq)
);
`default_nettype wire

// [bench/tb_cstat_regs.sv]
/*
 Self-checking bench for cstat_regs: register access, status fields,
 events, crossover loading and interrupt output.
 Assumes the checker binds itself from its own file.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_cstat_regs;
   logic clk_sys;
   logic rst;
   logic sw_reset;
   cstat_pkg::cstat_bus_t bus;
   logic [15:0] rdata;
   cstat_pkg::cstat_link_in_t link;
   cstat_pkg::cstat_cfg_t cfg;
   logic [15:0] ev_latched;
   logic [15:0] event_pulse;
   logic [3:0] pair_polarity;
   logic irq;
   int err_count;
   int comparisons;
   int evb [9] = '{15, 15, 15, 15, 9, 8, 3, 11, 12};
   logic [1:0] xm [6] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h3};
   logic [15:0] xe [7] = '{16'h40, 16'h0, 16'h40, 16'h0, 16'h40, 16'h0,
      16'h40};

   cstat_regs u_dut (
      .clk_sys(clk_sys),
      .rst(rst),
      .sw_reset(sw_reset),
      .bus(bus),
      .rdata(rdata),
      .link(link),
      .cfg(cfg),
      .ev_latched(ev_latched),
      .event_pulse(event_pulse),
      .pair_polarity(pair_polarity),
      .irq(irq)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic rchk(input logic [4:0] a, input logic [15:0] m,
      input logic [15:0] e);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1;
      chk(rdata & m, e);
   endtask

   task automatic soft_reset();
      @(posedge clk_sys);
      sw_reset <= 1'b1;
      @(posedge clk_sys);
      sw_reset <= 1'b0;
   endtask

   task automatic fire(input int k);
      cstat_pkg::cstat_link_in_t v;
      cstat_pkg::cstat_link_in_t s;
      s = link;
      v = link;
      case (k)
         0: v.ms_fault = 1'b1;
         1: v.pd_fault = 1'b1;
         2: v.no_hcd = 1'b1;
         3: v.link_fail_after_an = 1'b1;
         4: v.symbol_err = 1'b1;
         5: v.false_carrier = 1'b1;
         6: v.an_no_link = 1'b1;
         7: v.an_done = 1'b1;
         default: v.page_rx = 1'b1;
      endcase
      @(posedge clk_sys);
      link <= v;
      @(posedge clk_sys);
      link <= s;
      #1;
   endtask

   // Bounded so a stuck interrupt ends the run
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      #1;
      while (irq !== v && n < 8)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (irq !== v)
      begin
         err_count++;
         print_verdict();
      end
      chk({15'h0, irq}, {15'h0, v});
   endtask

   initial
   begin
      err_count = 0;
      comparisons = 0;
      rst = 1'b1;
      sw_reset = 1'b0;
      bus = '0;
      link = '0;
      link.an_enable = 1'b1;
      link.mdix_auto = 1'b1;
      cfg.xover_mode = cstat_pkg::XOVER_AUTO;
      cfg.pol_rev_disable = 1'b0;
      ev_latched = 16'h0000;
      cycles(20);
      rst <= 1'b0;
      rchk(5'h11, 16'hFFFF, 16'h8040);
      rchk(5'h12, 16'hFFFF, 16'h0000);
      wr(5'h12, 16'hFF5B);
      rchk(5'h12, 16'hFFFF, 16'hFF5B);
      wr(5'h11, 16'hFFFF);
      rchk(5'h11, 16'hFFFF, 16'h8040);
      rchk(5'h05, 16'hFFFF, 16'h0000);
      soft_reset();
      rchk(5'h12, 16'hFFFF, 16'hFF5B);
      wr(5'h12, 16'h0000);
      $display("registers done");
      for (int k = 0; k < 9; k++)
      begin
         fire(k);
         chk(event_pulse & (16'h1 << evb[k]), 16'h1 << evb[k]);
      end
      rchk(5'h11, 16'h1800, 16'h1800);
      rchk(5'h11, 16'h1000, 16'h0000);
      $display("events done");
      link.speed <= cstat_pkg::SPEED_100;
      link.duplex <= 1'b1;
      link.tx_pause <= 1'b1;
      link.link_rt <= 1'b1;
      link.link_global <= 1'b1;
      cycles(2);
      rchk(5'h11, 16'hFFFF, 16'h6E48);
      link.speed <= cstat_pkg::SPEED_10;
      link.duplex <= 1'b0;
      link.tx_pause <= 1'b0;
      link.rx_pause <= 1'b1;
      cycles(2);
      rchk(5'h11, 16'hFFFF, 16'h0D48);
      fire(9);
      link.an_restart <= 1'b1;
      cycles(1);
      link.an_restart <= 1'b0;
      cycles(2);
      rchk(5'h11, 16'h0800, 16'h0000);
      link.an_enable <= 1'b0;
      cycles(2);
      rchk(5'h11, 16'h0800, 16'h0800);
      $display("resolution done");
      link.polarity_rt <= 1'b1;
      link.jabber_rt <= 1'b1;
      link.energy_sleep <= 1'b1;
      cycles(2);
      rchk(5'h11, 16'h0013, 16'h0013);
      cfg.pol_rev_disable <= 1'b1;
      cycles(2);
      rchk(5'h11, 16'h0002, 16'h0000);
      link.speed <= cstat_pkg::SPEED_1000;
      link.pair_polarity <= 4'hA;
      cycles(3);
      #1;
      chk({12'h0, pair_polarity}, 16'h000A);
      link.speed <= cstat_pkg::SPEED_100;
      cycles(3);
      #1;
      chk({12'h0, pair_polarity}, 16'h0000);
      $display("live bits done");
      for (int k = 0; k < 6; k++)
      begin
         cfg.xover_mode <= cstat_pkg::cstat_xover_t'(xm[k]);
         cycles(2);
         rchk(5'h11, 16'h0040, xe[k]);
         soft_reset();
         cycles(2);
         rchk(5'h11, 16'h0040, xe[k + 1]);
      end
      $display("crossover done");
      wr(5'h12, 16'h1000);
      ev_latched <= 16'h1000;
      wait_irq(1'b1);
      ev_latched <= 16'h0800;
      wait_irq(1'b0);
      wr(5'h12, 16'h0800);
      wait_irq(1'b1);
      wr(5'h12, 16'h0000);
      wait_irq(1'b0);
      $display("interrupt done");
      print_verdict();
   end
endmodule
`default_nettype wire
